/* File: verification/scwd_prog_model.sv */
// Partner model: user program pass length and host link traffic
`timescale 1ns/1ps

module scwd_prog_model
  import scwd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire scwd_phase_e phase,
  input  wire logic        iorf_busy,
  input  wire logic [31:0] exec_cycles,
  input  wire logic        host_work,
  output logic             exec_done,
  output logic             host_cmd_pending
);
  // ----------------------------------------
  // Program pass and host link
  // ----------------------------------------
  logic [31:0] run_q;
  logic        fired_q;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      run_q            <= 32'h0;
      fired_q          <= 1'b0;
      exec_done        <= 1'b0;
      host_cmd_pending <= 1'b0;
    end
    else
    begin
      host_cmd_pending <= host_work;
      exec_done        <= 1'b0;
      if (phase != PH_EXEC)
      begin
        run_q   <= 32'h0;
        fired_q <= 1'b0;
      end
      else
      begin
        run_q <= run_q + 32'h1;
        // The program cannot end its pass while its own refresh is running
        if (!fired_q && !iorf_busy && run_q >= exec_cycles)
        begin
          exec_done <= 1'b1;
          fired_q   <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the scan cycle watchdog supervisor
`timescale 1ns/1ps

module testbench
  import scwd_pkg::*;
;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  localparam int TD = 4;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  scwd_bus_s   bus = '0;
  scwd_wdt_s   wdt_instr = '0;
  scwd_iorf_s  iorf_instr = '0;
  logic [31:0] exec_cycles = 32'h1f40;
  logic        host_work = 1'b1;
  logic [31:0] rdata;
  logic        exec_done, host_cmd_pending, halted, watchdog_restart, io_cycle_refresh;
  logic        iorf_busy, io_word_strobe, io_word_is_input, irq;
  logic [5:0]  io_word_idx;
  logic [7:0]  fatal_alarm;
  scwd_phase_e phase;
  scwd_flags_s timing_flags;
  int          bad_count = 0, checked = 0, seed = 10, cyc = 0, wd_lim, c, t, cur1, cur2, b;
  logic [31:0] r, d;
  logic [6:0]  got_q[$], exp_q[$];

  scwd_supervisor #(.TICK_DIV(16'(TD))) i_dut (.core_clk(core_clk), .reset(reset), .bus(bus),
    .rdata(rdata), .exec_done(exec_done), .wdt_instr(wdt_instr), .iorf_instr(iorf_instr),
    .host_cmd_pending(host_cmd_pending), .phase(phase), .halted(halted),
    .fatal_alarm(fatal_alarm), .timing_flags(timing_flags), .watchdog_restart(watchdog_restart),
    .io_cycle_refresh(io_cycle_refresh), .iorf_busy(iorf_busy), .io_word_strobe(io_word_strobe),
    .io_word_idx(io_word_idx), .io_word_is_input(io_word_is_input), .irq(irq));

  scwd_prog_model i_prog (.core_clk(core_clk), .reset(reset), .phase(phase),
    .iorf_busy(iorf_busy), .exec_cycles(exec_cycles), .host_work(host_work),
    .exec_done(exec_done), .host_cmd_pending(host_cmd_pending));

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cyc <= watchdog_restart ? 1 : cyc + 1;
    if (io_word_strobe === 1'b1)
      got_q.push_back({io_word_is_input, io_word_idx});
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic near(input int a, input int b, input int tol);
    return (a - b <= tol) && (b - a <= tol);
  endfunction

  // Servicing share in ticks: percent of the base cycle, rounded up, never below the floor
  function automatic int share_t(input int pct, input int lo, input int base);
    return ((pct * base + 99) / 100 > lo) ? (pct * base + 99) / 100 : lo;
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    bus <= '0;
    #1 v = rdata;
  endtask

  task automatic wait_ph(input scwd_phase_e ph);
    int n = 0;
    while (phase !== ph)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 70000)
      begin
        bad_count++;
        $display("wrong value phase expected %h seen %h", ph, phase);
        tally_and_finish();
      end
    end
  endtask

  task automatic span(input scwd_phase_e ph, output int n);
    wait_ph(ph);
    n = 0;
    while (phase === ph && n < 70000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 70000)
    begin
      bad_count++;
      $display("wrong value span expected %h seen %h", ph, phase);
      tally_and_finish();
    end
  endtask

  task automatic wdt(input logic cnd, input logic [5:0] op);
    @(posedge core_clk);
    wdt_instr <= '{valid: 1'b1, cond: cnd, operand: op};
    @(posedge core_clk);
    wdt_instr <= '0;
    if (cnd)
      wd_lim = (wd_lim + 10000 * op > 'hfffff) ? 'hfffff : wd_lim + 10000 * op;
  endtask

  task automatic iorf(input logic cnd, input logic inp, input logic [5:0] f, input logic [5:0] l);
    @(posedge core_clk);
    iorf_instr <= '{valid: 1'b1, cond: cnd, is_input: inp, first: f, last: l};
    @(posedge core_clk);
    iorf_instr <= '0;
    #1;
  endtask

  task automatic close_cycle(input int cy, output int cur);
    int k;
    k = cy / TD;
    check(watchdog_restart, 1'b1, "restart");
    reg_rd(REG_CUR_CYC, d);
    cur = int'(d);
    check(near(cur * TD, cy, 2 * TD), 1'b1, "cur_cyc");
    check(timing_flags, {k >= 1000, k >= 2000, k >= 10000, k >= 20000}, "flags");
    reg_rd(REG_WD_LIM, d);
    check(d, 32'(WD_DEFAULT_T), "wd_lim_back");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1;
    check(phase, PH_INIT, "reset_phase");
    check({halted, fatal_alarm, irq}, 10'h0, "reset_out");
    @(posedge core_clk);
    reset <= 1'b0;
    span(PH_INIT, c);
    check(near(c, 3 * TD, TD), 1'b1, "init_len");
    check(watchdog_restart, 1'b1, "restart");
    span(PH_OVERSEE, c);
    check(near(c, 290 * TD, TD), 1'b1, "oversee_len");
    $display("test init done");
    wd_lim = 13000;
    reg_rd(REG_WD_LIM, d);
    check(d, 32'(wd_lim), "wd_default");
    wdt(1'b0, 6'h3f);
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      wdt(r[6], r[5:0]);
      reg_rd(REG_WD_LIM, d);
      check(d, 32'(wd_lim), "wd_extend");
    end
    check(timing_flags, 4'h0, "flags_kept");
    reg_wr(REG_MAX_CYC, 32'h1234);
    reg_rd(REG_MAX_CYC, d);
    check(d, 32'h0, "ro_write");
    reg_rd(8'h40, d);
    check(d, 32'h0, "unmapped");
    $display("test watchdog extend done");
    reg_wr(REG_IO_CFG, 32'h0102);
    reg_wr(REG_SVC_CFG, 32'h0080);
    reg_wr(REG_MASK, 32'h8);
    iorf(1'b0, 1'b1, 6'h2, 6'h3);
    check(iorf_busy, 1'b0, "iorf_off");
    r = $random(seed);
    for (int w = r[4:0]; w <= r[4:0] + r[7:5]; w++)
      exp_q.push_back({r[8], 6'(w)});
    got_q.delete();
    iorf(1'b1, r[8], 6'(r[4:0]), 6'(r[4:0] + r[7:5]));
    check(iorf_busy, 1'b1, "iorf_busy");
    c = 0;
    while (iorf_busy === 1'b1 && c < 5000)
    begin
      @(posedge core_clk);
      #1;
      c++;
    end
    t = (60 + exp_q.size() * (r[8] ? 14 : 8)) * TD;
    check(near(c, t, 2 * TD), 1'b1, "iorf_time");
    @(posedge core_clk);
    #1;
    check(got_q.size(), exp_q.size(), "word_count");
    foreach (exp_q[i])
      check(got_q[i], exp_q[i], "word");
    check(irq, 1'b1, "irq_set");
    reg_rd(REG_STATUS, d);
    check(d[3], 1'b1, "status_iorf");
    check(irq, 1'b0, "irq_clear");
    $display("test immediate refresh done");
    span(PH_ADJUST, c);
    check(c < 100 * TD, 1'b1, "adjust_len");
    span(PH_REFRESH, c);
    check(near(c, 18 * TD, TD), 1'b1, "refresh_len");
    b = cyc / TD;
    span(PH_SERIAL, c);
    check(near(c, 20 * TD, TD), 1'b1, "serial_len");
    span(PH_HOST, c);
    check(near(c, 800 * TD, TD), 1'b1, "host_len");
    span(PH_PERIPH, c);
    t = cyc;
    check(near(c, share_t(5, 100, b) * TD, 2 * TD), 1'b1, "periph_len");
    close_cycle(t, cur1);
    reg_rd(REG_MAX_CYC, d);
    check(d, 32'(cur1), "max_first");
    $display("test first cycle done");
    reg_wr(REG_ADJ, 32'h5dc);
    reg_wr(REG_SVC_CFG, 32'hff00);
    exec_cycles <= 32'h28;
    host_work   <= 1'b0;
    span(PH_ADJUST, c);
    check(near(cyc, 1500 * TD, 2 * TD), 1'b1, "pad_end");
    check(io_cycle_refresh, 1'b1, "io_refresh");
    span(PH_REFRESH, c);
    b = cyc / TD;
    span(PH_SERIAL, c);
    check(near(c, share_t(5, 100, b) * TD, 2 * TD), 1'b1, "serial_dflt");
    span(PH_HOST, c);
    check(near(c, TD, TD), 1'b1, "host_idle");
    span(PH_PERIPH, c);
    t = cyc;
    check(near(c, share_t(99, 20, b) * TD, 2 * TD), 1'b1, "periph_clamp");
    close_cycle(t, cur2);
    reg_rd(REG_MAX_CYC, d);
    check(d, 32'(cur1 > cur2 ? cur1 : cur2), "max_kept");
    $display("test padded cycle done");
    reg_wr(REG_MASK, 32'h1);
    exec_cycles <= 32'hffffffff;
    wait_ph(PH_HALT);
    check(near(cyc, 13001 * TD, 2 * TD), 1'b1, "overrun_at");
    check(fatal_alarm, FATAL_WD, "fatal");
    check({halted, irq}, 2'h3, "halt_irq");
    reg_rd(REG_FLAGS, d);
    check(d[16:8], {1'b1, FATAL_WD}, "flags_reg");
    repeat (100) @(posedge core_clk);
    #1;
    check(phase, PH_HALT, "stays_halted");
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    span(PH_INIT, c);
    check(near(c, 3 * TD, TD), 1'b1, "reinit_len");
    check({halted, fatal_alarm}, 9'h0, "reset_clears");
    $display("test overrun done");
    tally_and_finish();
  end
endmodule

/* File: verilog/scwd_pkg.sv */
// Package: constants, states and carriers of the scan cycle watchdog supervisor
package scwd_pkg;

  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 10;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;

  // Times in their own units, as printed
  localparam int WD_DEFAULT_MS = 130;
  localparam int WD_STEP_MS    = 100;
  localparam int HARD_LIM_MS   = 6500;
  localparam int CYC_ERR_MS    = 100;
  localparam int FAST_TMR_MS   = 10;
  localparam int PULSE002_MS   = 20;
  localparam int PULSE02_MS    = 200;
  localparam int OVERSEE_US    = 2900;
  localparam int IN_GRP_US     = 70;
  localparam int OUT_GRP_US    = 40;
  localparam int SVC_MIN_US    = 200;
  localparam int SVC_DMIN_US   = 1000;
  localparam int HOST_MAX_US   = 8000;
  localparam int IORF_BASE_US  = 600;
  localparam int IORF_IN_US    = 70 * 2;
  localparam int IORF_OUT_US   = 40 * 2;

  // Times in 10 us ticks; least times and the hard limit round up, other longest times round down
  localparam logic [19:0] WD_DEFAULT_T = 20'(WD_DEFAULT_MS * 1000 / TICK_US);
  localparam logic [19:0] WD_STEP_T    = 20'(WD_STEP_MS * 1000 / TICK_US);
  localparam logic [19:0] HARD_LIM_T   = 20'((HARD_LIM_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [19:0] CYC_ERR_T    = 20'(CYC_ERR_MS * 1000 / TICK_US);
  localparam logic [19:0] FAST_TMR_T   = 20'(FAST_TMR_MS * 1000 / TICK_US);
  localparam logic [19:0] PULSE002_T   = 20'(PULSE002_MS * 1000 / TICK_US);
  localparam logic [19:0] PULSE02_T    = 20'(PULSE02_MS * 1000 / TICK_US);
  localparam logic [19:0] OVERSEE_T    = 20'((OVERSEE_US + TICK_US - 1) / TICK_US);
  localparam logic [19:0] IN_GRP_T     = 20'((IN_GRP_US + TICK_US - 1) / TICK_US);
  localparam logic [19:0] OUT_GRP_T    = 20'((OUT_GRP_US + TICK_US - 1) / TICK_US);
  localparam logic [19:0] SVC_MIN_T    = 20'((SVC_MIN_US + TICK_US - 1) / TICK_US);
  localparam logic [19:0] SVC_DMIN_T   = 20'((SVC_DMIN_US + TICK_US - 1) / TICK_US);
  localparam logic [19:0] HOST_MAX_T   = 20'(HOST_MAX_US / TICK_US);
  localparam logic [19:0] IORF_BASE_T  = 20'((IORF_BASE_US + TICK_US - 1) / TICK_US);
  localparam logic [19:0] IORF_IN_T    = 20'((IORF_IN_US + TICK_US - 1) / TICK_US);
  localparam logic [19:0] IORF_OUT_T   = 20'((IORF_OUT_US + TICK_US - 1) / TICK_US);

  // ----------------------------------------
  // Codes and ranges
  // ----------------------------------------
  localparam logic [7:0] FATAL_WD     = 8'h9f;
  localparam logic [6:0] SVC_DEF_PCT  = 7'h05;
  localparam logic [6:0] SVC_MAX_PCT  = 7'h63;
  localparam logic [6:0] PCT_SCALE    = 7'h64;
  localparam logic [5:0] IO_WORD_LAST = 6'h27;
  localparam logic [1:0] INIT_STEPS   = 2'h3;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_SVC_CFG = 8'h00;
  localparam logic [7:0] REG_ADJ     = 8'h04;
  localparam logic [7:0] REG_IO_CFG  = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_MASK    = 8'h10;
  localparam logic [7:0] REG_MAX_CYC = 8'h14;
  localparam logic [7:0] REG_CUR_CYC = 8'h18;
  localparam logic [7:0] REG_FLAGS   = 8'h1c;
  localparam logic [7:0] REG_WD_LIM  = 8'h20;

  // Status and mask bit positions
  localparam int ST_FATAL   = 0;
  localparam int ST_CYC_ERR = 1;
  localparam int ST_CYC_END = 2;
  localparam int ST_IORF    = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [8:0] {
    PH_INIT    = 9'h001,
    PH_OVERSEE = 9'h002,
    PH_EXEC    = 9'h004,
    PH_ADJUST  = 9'h008,
    PH_REFRESH = 9'h010,
    PH_SERIAL  = 9'h020,
    PH_HOST    = 9'h040,
    PH_PERIPH  = 9'h080,
    PH_HALT    = 9'h100
  } scwd_phase_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } scwd_bus_s;

  typedef struct packed {
    logic       valid;
    logic       cond;
    logic [5:0] operand;
  } scwd_wdt_s;

  typedef struct packed {
    logic       valid;
    logic       cond;
    logic       is_input;
    logic [5:0] first;
    logic [5:0] last;
  } scwd_iorf_s;

  typedef struct packed {
    logic fast_timer_bad;
    logic pulse002_bad;
    logic cycle_timer_err;
    logic pulse02_bad;
  } scwd_flags_s;

endpackage

/* File: verilog/scwd_supervisor.sv */
// Scan cycle sequencer, cycle timer, watchdog and immediate I/O refresh engine
//
// Contract
// - Extend instruction adds 100 ms times operand
// - Default watchdog limit is 130 ms
// - Cycle over limit halts with code 9F
// - Cycle reaching 6500 ms always halts, 9F
// - Cycle of 100 ms sets cycle-timer error
// - Flag degraded timing at 10, 20, 200 ms
// - Refresh instruction refreshes words first to last
// - Refresh takes 600 us plus per-word time
// - Neither instruction alters condition flags
// - Keep maximum and current cycle times
// - Three init steps once, then cycle forever
// - Cycle opens with 2.9 ms overseeing phase
// - Adjust phase pads cycle, else under 1 ms
// - I/O refresh 0.07/0.04 ms per 8 points
// - Serial and peripheral share, 0.2/1 ms minimum
// - Host link phase at most 8 ms
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps

module scwd_supervisor
  import scwd_pkg::*;
#(
  parameter logic [15:0] TICK_DIV = 16'(TICK_CYCLES)
)(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire scwd_bus_s   bus,
  output logic      [31:0] rdata,
  input  wire logic        exec_done,
  input  wire scwd_wdt_s   wdt_instr,
  input  wire scwd_iorf_s  iorf_instr,
  input  wire logic        host_cmd_pending,
  output scwd_phase_e      phase,
  output logic             halted,
  output logic      [7:0]  fatal_alarm,
  output scwd_flags_s      timing_flags,
  output logic             watchdog_restart,
  output logic             io_cycle_refresh,
  output logic             iorf_busy,
  output logic             io_word_strobe,
  output logic      [5:0]  io_word_idx,
  output logic             io_word_is_input,
  output logic             irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    scwd_phase_e phase;
    logic [15:0] div;
    logic [19:0] cyc;
    logic [19:0] ph;
    logic [19:0] base;
    logic [19:0] lim;
    logic [19:0] cur;
    logic [19:0] max;
    logic [15:0] svc_cfg;
    logic [19:0] adj;
    logic [15:0] io_cfg;
    logic [3:0]  status;
    logic [3:0]  mask;
    scwd_flags_s flags;
    logic [7:0]  fatal;
    logic [31:0] rdata;
    logic        wd_rst;
    logic        rf_busy;
    logic        rf_in;
    logic [5:0]  rf_word;
    logic [5:0]  rf_last;
    logic [19:0] rf_cnt;
    logic        rf_stb;
    logic [5:0]  rf_idx;
  } scwd_state_s;

  scwd_state_s s_q;
  scwd_state_s s_d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Share check by cross-multiplying avoids a divider in the loop
  function automatic logic share_done(input logic [19:0] ph, input logic [7:0] cfg,
                                      input logic [19:0] base);
    logic [6:0]  pct;
    logic [19:0] lo;
    pct = cfg[7] ? ((cfg[6:0] > SVC_MAX_PCT) ? SVC_MAX_PCT : cfg[6:0]) : SVC_DEF_PCT;
    lo  = cfg[7] ? SVC_MIN_T : SVC_DMIN_T;
    return (ph >= lo) && (27'(ph) * 27'(PCT_SCALE) >= 27'(pct) * 27'(base));
  endfunction

  function automatic logic [19:0] add_sat(input logic [19:0] a, input logic [20:0] b);
    logic [20:0] sum;
    sum = 21'(a) + b;
    return sum[20] ? 20'hfffff : sum[19:0];
  endfunction

  logic        tick;
  logic        running;
  logic [19:0] cyc_nx;
  logic [19:0] ph_nx;
  logic [19:0] refresh_t;
  logic [3:0]  ev;
  logic [3:0]  clr;

  assign tick      = (s_q.div == TICK_DIV - 16'h0001);
  assign running   = !(s_q.phase inside {PH_INIT, PH_HALT});
  assign cyc_nx    = (running && tick) ? add_sat(s_q.cyc, 21'h000001) : s_q.cyc;
  assign ph_nx     = tick ? s_q.ph + 20'h00001 : s_q.ph;
  assign refresh_t = 20'(s_q.io_cfg[7:0] * IN_GRP_T) + 20'(s_q.io_cfg[15:8] * OUT_GRP_T);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d        = s_q;
    ev         = 4'h0;
    clr        = 4'h0;
    s_d.wd_rst = 1'b0;
    s_d.rf_stb = 1'b0;
    s_d.rdata  = 32'h0;
    s_d.div    = tick ? 16'h0000 : s_q.div + 16'h0001;
    s_d.cyc    = cyc_nx;
    s_d.ph     = ph_nx;

    // Register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        REG_SVC_CFG: s_d.svc_cfg = bus.wdata[15:0];
        REG_ADJ:     s_d.adj     = bus.wdata[19:0];
        REG_IO_CFG:  s_d.io_cfg  = bus.wdata[15:0];
        REG_MASK:    s_d.mask    = bus.wdata[3:0];
        default:     ;
      endcase
    end

    // Register reads; a status read clears what it returned
    if (bus.rd)
    begin
      unique case (bus.addr)
        REG_SVC_CFG: s_d.rdata = {16'h0, s_q.svc_cfg};
        REG_ADJ:     s_d.rdata = {12'h0, s_q.adj};
        REG_IO_CFG:  s_d.rdata = {16'h0, s_q.io_cfg};
        REG_STATUS:
        begin
          s_d.rdata = {28'h0, s_q.status};
          clr       = s_q.status;
        end
        REG_MASK:    s_d.rdata = {28'h0, s_q.mask};
        REG_MAX_CYC: s_d.rdata = {12'h0, s_q.max};
        REG_CUR_CYC: s_d.rdata = {12'h0, s_q.cur};
        REG_FLAGS:   s_d.rdata = {15'h0, s_q.phase == PH_HALT, s_q.fatal, 4'h0, s_q.flags};
        REG_WD_LIM:  s_d.rdata = {12'h0, s_q.lim};
        default:     s_d.rdata = 32'h0;
      endcase
    end

    // Phase sequencer
    unique case (s_q.phase)
      PH_INIT:
      begin
        if (tick && s_q.ph[1:0] == INIT_STEPS - 2'h1)
        begin
          s_d.phase  = PH_OVERSEE;
          s_d.ph     = 20'h0;
          s_d.cyc    = 20'h0;
          s_d.lim    = WD_DEFAULT_T;
          s_d.wd_rst = 1'b1;
        end
      end
      PH_OVERSEE:
      begin
        if (tick && s_q.ph == OVERSEE_T - 20'h1)
        begin
          s_d.phase = PH_EXEC;
          s_d.ph    = 20'h0;
        end
      end
      PH_EXEC:
      begin
        // Both instructions leave condition flags alone; none are driven here
        if (wdt_instr.valid && wdt_instr.cond)
          s_d.lim = add_sat(s_q.lim, 21'(wdt_instr.operand) * 21'(WD_STEP_T));
        if (iorf_instr.valid && iorf_instr.cond && !s_q.rf_busy)
        begin
          s_d.rf_busy = 1'b1;
          s_d.rf_in   = iorf_instr.is_input;
          s_d.rf_word = iorf_instr.first;
          s_d.rf_last = iorf_instr.last;
          s_d.rf_cnt  = 20'h0;
        end
        if (exec_done && !s_q.rf_busy)
        begin
          s_d.phase = PH_ADJUST;
          s_d.ph    = 20'h0;
        end
      end
      PH_ADJUST:
      begin
        // Unpadded cycles leave on the next tick, well under 1 ms
        if (tick && s_q.cyc >= s_q.adj)
        begin
          s_d.phase = PH_REFRESH;
          s_d.ph    = 20'h0;
        end
      end
      PH_REFRESH:
      begin
        if (tick && ph_nx >= refresh_t)
        begin
          s_d.phase = PH_SERIAL;
          s_d.ph    = 20'h0;
          s_d.base  = s_q.cyc;
        end
      end
      PH_SERIAL:
      begin
        if (tick && share_done(ph_nx, s_q.svc_cfg[7:0], s_q.base))
        begin
          s_d.phase = PH_HOST;
          s_d.ph    = 20'h0;
        end
      end
      PH_HOST:
      begin
        if (tick && (!host_cmd_pending || ph_nx >= HOST_MAX_T))
        begin
          s_d.phase = PH_PERIPH;
          s_d.ph    = 20'h0;
        end
      end
      PH_PERIPH:
      begin
        if (tick && share_done(ph_nx, s_q.svc_cfg[15:8], s_q.base))
        begin
          s_d.cur                   = cyc_nx;
          s_d.max                   = (cyc_nx > s_q.max) ? cyc_nx : s_q.max;
          s_d.flags.fast_timer_bad  = cyc_nx >= FAST_TMR_T;
          s_d.flags.pulse002_bad    = cyc_nx >= PULSE002_T;
          s_d.flags.cycle_timer_err = cyc_nx >= CYC_ERR_T;
          s_d.flags.pulse02_bad     = cyc_nx >= PULSE02_T;
          ev[ST_CYC_END]            = 1'b1;
          ev[ST_CYC_ERR]            = cyc_nx >= CYC_ERR_T;
          s_d.phase                 = PH_OVERSEE;
          s_d.ph                    = 20'h0;
          s_d.cyc                   = 20'h0;
          s_d.lim                   = WD_DEFAULT_T;
          s_d.wd_rst                = 1'b1;
        end
      end
      PH_HALT: ;
    endcase

    // Immediate refresh: setup time, then one slot per word
    if (s_q.rf_busy && tick)
    begin
      s_d.rf_cnt = s_q.rf_cnt + 20'h1;
      if (s_q.rf_cnt + 20'h1 >= IORF_BASE_T + (s_q.rf_in ? IORF_IN_T : IORF_OUT_T))
      begin
        s_d.rf_stb  = 1'b1;
        s_d.rf_idx  = s_q.rf_word;
        s_d.rf_cnt  = IORF_BASE_T;
        s_d.rf_word = s_q.rf_word + 6'h1;
        if (s_q.rf_word >= s_q.rf_last || s_q.rf_word >= IO_WORD_LAST)
        begin
          s_d.rf_busy  = 1'b0;
          ev[ST_IORF]  = 1'b1;
        end
      end
    end

    // Overrun checks win over any phase change
    if (running && tick && (cyc_nx > s_q.lim || cyc_nx >= HARD_LIM_T))
    begin
      s_d.phase      = PH_HALT;
      s_d.fatal      = FATAL_WD;
      s_d.rf_busy    = 1'b0;
      ev[ST_FATAL]   = 1'b1;
    end

    // A new event beats a read clearing the same bit
    s_d.status = (s_q.status & ~clr) | ev;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q       <= '0;
      s_q.phase <= PH_INIT;
      s_q.lim   <= WD_DEFAULT_T;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata            = s_q.rdata;
  assign phase            = s_q.phase;
  assign halted           = (s_q.phase == PH_HALT);
  assign fatal_alarm      = s_q.fatal;
  assign timing_flags     = s_q.flags;
  assign watchdog_restart = s_q.wd_rst && running;
  assign io_cycle_refresh = (s_q.phase == PH_REFRESH);
  assign iorf_busy        = s_q.rf_busy;
  assign io_word_strobe   = s_q.rf_stb;
  assign io_word_idx      = s_q.rf_idx;
  assign io_word_is_input = s_q.rf_in;
  assign irq              = |(s_q.status & s_q.mask);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_overrun_halts;
    @(posedge core_clk) disable iff (reset)
    running && tick && add_sat(s_q.cyc, 21'h1) > s_q.lim |=> halted && fatal_alarm == 8'h9f;
  endproperty
  a_overrun_halts: assert property (p_overrun_halts)
    else $error("cycle overran the limit without halting on 9F");

  property p_hard_limit;
    @(posedge core_clk) disable iff (reset)
    running && tick && s_q.cyc == 20'd649999 |=> halted;
  endproperty
  a_hard_limit: assert property (p_hard_limit)
    else $error("6500 ms cycle did not halt");

  property p_default_limit;
    @(posedge core_clk) disable iff (reset)
    watchdog_restart |-> s_q.lim == 20'd13000 && s_q.cyc == 20'd0 && phase == PH_OVERSEE;
  endproperty
  a_default_limit: assert property (p_default_limit)
    else $error("watchdog not restarted at 130 ms");

  property p_extend;
    @(posedge core_clk) disable iff (reset)
    phase == PH_EXEC && wdt_instr.valid && wdt_instr.cond && !(running && tick)
      |=> s_q.lim == add_sat($past(s_q.lim), 21'($past(wdt_instr.operand)) * 21'd10000);
  endproperty
  a_extend: assert property (p_extend)
    else $error("extend did not add 100 ms per step");

  property p_extend_off;
    @(posedge core_clk) disable iff (reset)
    phase == PH_EXEC && wdt_instr.valid && !wdt_instr.cond |=> $stable(s_q.lim);
  endproperty
  a_extend_off: assert property (p_extend_off)
    else $error("extend acted with its condition off");

  property p_oversee_len;
    @(posedge core_clk) disable iff (reset)
    phase == PH_OVERSEE && tick && s_q.ph < 20'd289 |=> phase inside {PH_OVERSEE, PH_HALT};
  endproperty
  a_oversee_len: assert property (p_oversee_len)
    else $error("overseeing phase ended before 2.9 ms");

  property p_cycle_record;
    @(posedge core_clk) disable iff (reset)
    watchdog_restart && $past(phase) == PH_PERIPH
      |-> s_q.cur == $past(cyc_nx) && s_q.max >= s_q.cur;
  endproperty
  a_cycle_record: assert property (p_cycle_record)
    else $error("current or maximum cycle time wrong");

  property p_cycle_err;
    @(posedge core_clk) disable iff (reset)
    watchdog_restart && $past(phase) == PH_PERIPH
      |-> timing_flags.cycle_timer_err == (s_q.cur >= 20'd10000);
  endproperty
  a_cycle_err: assert property (p_cycle_err)
    else $error("cycle-timer error flag disagrees with cycle time");

  property p_host_max;
    @(posedge core_clk) disable iff (reset)
    phase == PH_HOST && tick && s_q.ph == 20'd799 |=> phase != PH_HOST;
  endproperty
  a_host_max: assert property (p_host_max)
    else $error("host link phase ran past 8 ms");

  property p_iorf_off;
    @(posedge core_clk) disable iff (reset)
    iorf_instr.valid && !iorf_instr.cond && !iorf_busy |=> !iorf_busy;
  endproperty
  a_iorf_off: assert property (p_iorf_off)
    else $error("refresh started with its condition off");

  property p_status_sticky;
    @(posedge core_clk) disable iff (reset)
    s_q.status[ST_FATAL] && !(bus.rd && bus.addr == REG_STATUS) |=> s_q.status[ST_FATAL];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("fatal status bit dropped without a read");

endmodule
